// *** logic/uwm_defs.svh ***
// constants for the unsigned word multiply unit
// Contract
// - major 10, secondary opcode 001010 or 011010
// - low word times register or immediate
// - product to destination, high word saved
// - operands unsigned, no sign correction
// - plain form keeps all condition codes
// - icc.n from bit 31, icc.z low word
// - xcc.n from bit 63, xcc.z whole product
// - flag form clears v and c flags
// - register form with bits 12:5 set illegal
`ifndef UWM_DEFS_SVH
`define UWM_DEFS_SVH

// instruction fields
`define UWM_MAJ_HI      31
`define UWM_MAJ_LO      30
`define UWM_DST_HI      29
`define UWM_DST_LO      25
`define UWM_SOP_HI      24
`define UWM_SOP_LO      19
`define UWM_SRCA_HI     18
`define UWM_SRCA_LO     14
`define UWM_IMMSEL_BIT  13
`define UWM_IMM_HI      12
`define UWM_RSV_HI      12
`define UWM_RSV_LO      5
`define UWM_SRCB_HI     4
`define UWM_SRCB_LO     0
`define UWM_SEXT_FILL   19

`define UWM_MAJOR       2'h2
`define UWM_SOP_PLAIN   6'h0a
`define UWM_SOP_FLAGS   6'h1a

// condition-code nibble bits; 64-bit set in upper nibble
`define UWM_CC_N        3
`define UWM_CC_Z        2
`define UWM_CC_V        1
`define UWM_CC_C        0
`define UWM_CC_VC_W     2'h0
`define UWM_ICC_HI      3
`define UWM_ICC_LO      0
`define UWM_XCC_HI      7
`define UWM_XCC_LO      4

// register map
`define UWM_ADDR_CTRL   12'h000
`define UWM_ADDR_STATUS 12'h004
`define UWM_ADDR_MASK   12'h008
`define UWM_ADDR_PHI    12'h00c
`define UWM_ADDR_COUNT  12'h010

`define UWM_CTRL_EN     0
`define UWM_CTRL_RST    1'h1
`define UWM_ST_DONE     0
`define UWM_ST_ILL      1
`define UWM_ST_RST      2'h0
`define UWM_MASK_RST    2'h0
`define UWM_COUNT_RST   32'h0000_0000
`define UWM_COUNT_ONE   32'h0000_0001

`endif

// *** logic/uwm_pkg.sv ***
// types for the unsigned word multiply unit
package uwm_pkg;
   typedef enum logic [0:0] {UWM_IDLE, UWM_EXEC} uwm_state_t;
   typedef logic [3:0] uwm_cc_t;
   typedef logic [1:0] uwm_evt_t;
endpackage

// *** logic/uwm_unit.sv ***
// unsigned word multiply execution unit with apb control
`include "uwm_defs.svh"

module uwm_unit
   import uwm_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   output      logic        irq,
   input  wire logic        issue_valid,
   output      logic        issue_ready,
   input  wire logic [31:0] instr,
   input  wire logic [63:0] first_source_data,
   input  wire logic [63:0] second_source_data,
   input  wire logic [7:0]  cc_in,
   output      logic        done,
   output      logic        illegal,
   output      logic        dest_we,
   output      logic [4:0]  dest_num,
   output      logic [63:0] dest_data,
   output      logic        high_we,
   output      logic [31:0] high_data,
   output      logic        cc_we,
   output      logic [7:0]  cc_out
);

   function automatic logic [31:0] sext13(input logic [12:0] imm);
      sext13 = {{`UWM_SEXT_FILL{imm[`UWM_IMM_HI]}}, imm};
   endfunction

   // negative and zero set, overflow and carry cleared
   function automatic uwm_cc_t cc_nz(input logic n, input logic z);
      cc_nz = {n, z, `UWM_CC_VC_W};
   endfunction

   uwm_state_t  state_reg;
   logic        ctrl_en_reg;
   uwm_evt_t    status_reg;
   uwm_evt_t    mask_reg;
   logic [31:0] count_reg;
   logic [31:0] prdata_reg;
   logic        flags_reg;
   logic        known_reg;
   logic        bad_reg;
   logic [4:0]  dst_reg;
   logic [31:0] opa_reg;
   logic [31:0] opb_reg;
   logic [7:0]  cc_old_reg;

   logic        accept;
   logic        is_plain;
   logic        is_flags;
   logic        rsv_bad;
   logic [31:0] opb_sel;
   logic [63:0] product;
   logic        wr_acc;
   logic        rd_setup;
   logic        addr_hit;
   uwm_evt_t    evt;
   uwm_evt_t    w1c;
   logic [31:0] rd_mux;

   // decode of the issued word
   always_comb
   begin
      is_plain = instr[`UWM_MAJ_HI:`UWM_MAJ_LO] == `UWM_MAJOR &&
                 instr[`UWM_SOP_HI:`UWM_SOP_LO] == `UWM_SOP_PLAIN;
      is_flags = instr[`UWM_MAJ_HI:`UWM_MAJ_LO] == `UWM_MAJOR &&
                 instr[`UWM_SOP_HI:`UWM_SOP_LO] == `UWM_SOP_FLAGS;
      rsv_bad  = !instr[`UWM_IMMSEL_BIT] &&
                 (|instr[`UWM_RSV_HI:`UWM_RSV_LO]);
      // only the low word of either source takes part
      opb_sel  = instr[`UWM_IMMSEL_BIT] ?
                 sext13(instr[`UWM_IMM_HI:0]) :
                 second_source_data[31:0];
   end

   assign issue_ready = (state_reg == UWM_IDLE) && ctrl_en_reg;
   assign accept      = issue_valid && issue_ready;
   // zero-extended factors, so the product is unsigned
   assign product     = {32'h0000_0000, opa_reg} *
                        {32'h0000_0000, opb_reg};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= UWM_IDLE;
      else
      begin
         case (state_reg)
            UWM_IDLE:
               if (accept)
                  state_reg <= UWM_EXEC;
            UWM_EXEC:
               state_reg <= UWM_IDLE;
            default:
               state_reg <= UWM_IDLE;
         endcase
      end
   end

   // operand capture at issue
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags_reg  <= 1'b0;
         known_reg  <= 1'b0;
         bad_reg    <= 1'b0;
         dst_reg    <= 5'h00;
         opa_reg    <= 32'h0000_0000;
         opb_reg    <= 32'h0000_0000;
         cc_old_reg <= 8'h00;
      end
      else if (accept)
      begin
         flags_reg  <= is_flags;
         known_reg  <= is_plain || is_flags;
         bad_reg    <= rsv_bad;
         dst_reg    <= instr[`UWM_DST_HI:`UWM_DST_LO];
         opa_reg    <= first_source_data[31:0];
         opb_reg    <= opb_sel;
         cc_old_reg <= cc_in;
      end
   end

   // result stage; an illegal word writes nothing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done      <= 1'b0;
         illegal   <= 1'b0;
         dest_we   <= 1'b0;
         high_we   <= 1'b0;
         cc_we     <= 1'b0;
         dest_num  <= 5'h00;
         dest_data <= 64'h0;
         high_data <= 32'h0000_0000;
         cc_out    <= 8'h00;
      end
      else
      begin
         done    <= 1'b0;
         illegal <= 1'b0;
         dest_we <= 1'b0;
         high_we <= 1'b0;
         cc_we   <= 1'b0;
         if (state_reg == UWM_EXEC)
         begin
            if (!known_reg || bad_reg)
               illegal <= 1'b1;
            else
            begin
               done      <= 1'b1;
               dest_we   <= 1'b1;
               high_we   <= 1'b1;
               cc_we     <= flags_reg;
               dest_num  <= dst_reg;
               dest_data <= product;
               high_data <= product[63:32];
               if (flags_reg)
               begin
                  cc_out[`UWM_ICC_HI:`UWM_ICC_LO] <=
                     cc_nz(product[31], product[31:0] == 32'h0);
                  cc_out[`UWM_XCC_HI:`UWM_XCC_LO] <=
                     cc_nz(product[63], product == 64'h0);
               end
               else
                  cc_out <= cc_old_reg;
            end
         end
      end
   end

   // apb slave, zero wait states
   assign pready   = 1'b1;
   assign wr_acc   = psel && penable && pwrite && addr_hit;
   assign rd_setup = psel && !penable && !pwrite;
   assign pslverr  = psel && penable && !addr_hit;
   assign evt      = {illegal, done};
   assign w1c      = (wr_acc && paddr == `UWM_ADDR_STATUS && pstrb[0]) ?
                     pwdata[1:0] : 2'h0;
   assign irq      = |(status_reg & mask_reg);

   always_comb
   begin
      addr_hit = 1'b1;
      rd_mux   = 32'h0000_0000;
      if (paddr == `UWM_ADDR_CTRL)
         rd_mux[`UWM_CTRL_EN] = ctrl_en_reg;
      else if (paddr == `UWM_ADDR_STATUS)
         rd_mux[1:0] = status_reg;
      else if (paddr == `UWM_ADDR_MASK)
         rd_mux[1:0] = mask_reg;
      else if (paddr == `UWM_ADDR_PHI)
         rd_mux = high_data;
      else if (paddr == `UWM_ADDR_COUNT)
         rd_mux = count_reg;
      else
         addr_hit = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h0000_0000;
      else if (rd_setup)
         prdata_reg <= rd_mux;
   end
   assign prdata = prdata_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_en_reg <= `UWM_CTRL_RST;
         mask_reg    <= `UWM_MASK_RST;
      end
      else if (wr_acc && pstrb[0])
      begin
         if (paddr == `UWM_ADDR_CTRL)
            ctrl_en_reg <= pwdata[`UWM_CTRL_EN];
         else if (paddr == `UWM_ADDR_MASK)
            mask_reg <= pwdata[1:0];
      end
   end

   // a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_reg <= `UWM_ST_RST;
      else
         status_reg <= (status_reg & ~w1c) | evt;
   end

   // completed multiplies; wraps silently
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_reg <= `UWM_COUNT_RST;
      else if (done)
         count_reg <= count_reg + `UWM_COUNT_ONE;
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_KNOWN_OP: assert property (
      accept && (is_plain || is_flags) && !rsv_bad |-> ##2 done)
      else $error("recognised multiply did not complete");

   AST_PRODUCT: assert property (
      accept |-> ##2 (!dest_we || dest_data ==
         $past({32'h0, first_source_data[31:0]}, 2) *
         $past({32'h0, opb_sel}, 2)))
      else $error("product does not match issued operands");

   AST_HIGH: assert property (
      dest_we |-> high_we && high_data == dest_data[63:32])
      else $error("high word not copied with product");

   // both factors at least 2**31 give a product of at least 2**62
   AST_UNSIGNED: assert property (
      accept && opb_sel[31] && first_source_data[31] |-> ##2
         (!dest_we || dest_data[63] || dest_data[62]))
      else $error("large unsigned factors lost top bit");

   AST_PLAIN_CC: assert property (
      accept && is_plain && !rsv_bad |-> ##2
         !cc_we && cc_out == $past(cc_in, 2))
      else $error("plain multiply touched condition codes");

   AST_ICC: assert property (
      cc_we |-> cc_out[`UWM_CC_N] == dest_data[31] &&
         cc_out[`UWM_CC_Z] == (dest_data[31:0] == 32'h0))
      else $error("32-bit flags wrong");

   AST_XCC: assert property (
      cc_we |-> cc_out[`UWM_XCC_LO + `UWM_CC_N] == dest_data[63] &&
         cc_out[`UWM_XCC_LO + `UWM_CC_Z] == (dest_data == 64'h0))
      else $error("64-bit flags wrong");

   AST_VC_CLEAR: assert property (
      accept && is_flags && !rsv_bad |-> ##2 cc_we &&
         cc_out[`UWM_CC_V:`UWM_CC_C] == `UWM_CC_VC_W &&
         cc_out[`UWM_XCC_LO + `UWM_CC_V:`UWM_XCC_LO + `UWM_CC_C] ==
            `UWM_CC_VC_W)
      else $error("overflow or carry not cleared");

   AST_RSV_ILLEGAL: assert property (
      accept && rsv_bad |-> ##2 illegal)
      else $error("reserved bits did not raise illegal");

   AST_DEST_NUM: assert property (
      accept |-> ##2 (!dest_we ||
         dest_num == $past(instr[`UWM_DST_HI:`UWM_DST_LO], 2)))
      else $error("destination number mismatch");

   AST_SUPPRESS: assert property (
      illegal |-> !dest_we && !high_we && !cc_we && !done)
      else $error("write during illegal instruction");

   COV_PLAIN: cover property (accept && is_plain ##2 done);
   COV_FLAGS: cover property (accept && is_flags ##2 cc_we);
   COV_IMM:   cover property (accept && instr[`UWM_IMMSEL_BIT] ##2 done);
   COV_ILL:   cover property (accept && rsv_bad ##2 illegal);

endmodule

// *** verif/uwm_regfile.sv ***
// register file model feeding operands to the multiply unit
module uwm_regfile
(
   input  wire logic        pclk,
   input  wire logic [31:0] instr,
   input  wire logic        dest_we,
   input  wire logic [4:0]  dest_num,
   input  wire logic [63:0] dest_data,
   output      logic [63:0] first_source_data,
   output      logic [63:0] second_source_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] regs [32];
   // operands looked up by the register number fields
   assign first_source_data  = regs[instr[18:14]];
   assign second_source_data = regs[instr[4:0]];
   always @(posedge pclk)
      if (dest_we)
         regs[dest_num] <= dest_data;
endmodule

// *** verif/unsigned_word_multiply_tb.sv ***
// self-checking bench for the unsigned word multiply unit
`include "uwm_defs.svh"

module unsigned_word_multiply_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0;
   logic        presetn = 0;
   logic [11:0] paddr = '0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [31:0] pwdata = '0;
   logic [3:0]  pstrb = 4'hf;
   logic        issue_valid = 0;
   logic [31:0] instr = '0;
   logic [7:0]  cc_in = 8'ha5;
   logic [31:0] prdata, high_data;
   logic [63:0] srca, srcb, dest_data;
   logic        pready, pslverr, irq, issue_ready, done, illegal;
   logic        dest_we, high_we, cc_we;
   logic [4:0]  dest_num;
   logic [7:0]  cc_out;
   int          failures = 0;
   int          check_count = 0;

   uwm_unit u_uwm_unit (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq, .issue_valid,
      .issue_ready, .instr, .first_source_data(srca),
      .second_source_data(srcb), .cc_in, .done, .illegal, .dest_we,
      .dest_num, .dest_data, .high_we, .high_data, .cc_we, .cc_out);
   uwm_regfile u_uwm_regfile (.pclk, .instr, .dest_we, .dest_num,
      .dest_data, .first_source_data(srca), .second_source_data(srcb));

   always #2.5 pclk = ~pclk;

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1;
      penable <= 0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1;
      // release only after the edge that sees pready
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 0;
      penable <= 0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
      input logic ee);
      logic [31:0] v;
      logic        er;
      apb(a, 1'b0, 32'h0, v, er);
      chk(v, e);
      chk(er, ee);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic        er;
      apb(a, 1'b1, d, v, er);
   endtask

   function automatic logic [31:0] mk(input logic [5:0] sop,
      input logic [4:0] src_a, input logic i, input logic [12:0] lo);
      return {2'b10, 5'h05, sop, src_a, i, lo};
   endfunction

   // ok low expects the exception and unchanged data outputs
   task automatic do_op(input logic [31:0] ins, input logic ok,
      input logic [63:0] d, input logic [7:0] cc, input logic cwe);
      int n = 0;
      @(posedge pclk);
      instr       <= ins;
      issue_valid <= 1;
      do
         @(negedge pclk);
      while (issue_ready !== 1'b1);
      @(posedge pclk);
      issue_valid <= 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while (done !== 1'b1 && illegal !== 1'b1 && n < 8);
      chk(n, 2);
      chk(done, ok);
      chk(illegal, !ok);
      chk(dest_we, ok);
      chk(high_we, ok);
      chk(cc_we, cwe);
      chk(dest_data, d);
      chk(high_data, d[63:32]);
      chk(cc_out, cc);
      if (ok)
         chk(dest_num, 5'h05);
   endtask

   task automatic t_reset;
      rd_chk(`UWM_ADDR_CTRL, 32'h1, 1'b0);
      rd_chk(`UWM_ADDR_STATUS, 32'h0, 1'b0);
      rd_chk(`UWM_ADDR_MASK, 32'h0, 1'b0);
      rd_chk(`UWM_ADDR_COUNT, 32'h0, 1'b0);
      rd_chk(12'h020, 32'h0, 1'b1);
      chk(pready, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_ops;
      do_op(mk(6'h0a, 5'h01, 1'b0, 13'h0002), 1, 64'hffff_fffe_0000_0001,
         8'ha5, 0);
      do_op(mk(6'h1a, 5'h01, 1'b0, 13'h0002), 1, 64'hffff_fffe_0000_0001,
         8'h80, 1);
      do_op(mk(6'h1a, 5'h03, 1'b1, 13'h1fff), 1, 64'h1_ffff_fffe,
         8'h08, 1);
      // reserved bits set are legal in the immediate form
      do_op(mk(6'h1a, 5'h00, 1'b1, 13'h1000), 1, 64'h0, 8'h44, 1);
      do_op(mk(6'h1a, 5'h04, 1'b1, 13'h0002), 1, 64'h1_0000_0000,
         8'h04, 1);
      $display("test multiply done");
   endtask

   task automatic t_illegal;
      do_op(mk(6'h0a, 5'h01, 1'b0, 13'h0022), 0, 64'h1_0000_0000,
         8'h04, 0);
      do_op(mk(6'h1a, 5'h01, 1'b1, 13'h0002) ^ 32'h4000_0000, 0,
         64'h1_0000_0000, 8'h04, 0);
      do_op(mk(6'h0b, 5'h01, 1'b1, 13'h0002), 0, 64'h1_0000_0000,
         8'h04, 0);
      $display("test illegal done");
   endtask

   task automatic t_regs;
      rd_chk(`UWM_ADDR_COUNT, 32'h5, 1'b0);
      rd_chk(`UWM_ADDR_PHI, 32'h1, 1'b0);
      rd_chk(`UWM_ADDR_STATUS, 32'h3, 1'b0);
      chk(irq, 0);
      wr(`UWM_ADDR_MASK, 32'h2);
      @(negedge pclk);
      chk(irq, 1);
      wr(`UWM_ADDR_STATUS, 32'h2);
      @(negedge pclk);
      chk(irq, 0);
      rd_chk(`UWM_ADDR_STATUS, 32'h1, 1'b0);
      wr(`UWM_ADDR_CTRL, 32'h0);
      @(negedge pclk);
      chk(issue_ready, 0);
      wr(`UWM_ADDR_CTRL, 32'h1);
      // a write without lane 0 must leave the mask alone
      pstrb <= 4'h0;
      wr(`UWM_ADDR_MASK, 32'h0);
      pstrb <= 4'hf;
      rd_chk(`UWM_ADDR_MASK, 32'h2, 1'b0);
      $display("test registers done");
   endtask

   initial
   begin
      u_uwm_regfile.regs[0] = 64'h0;
      u_uwm_regfile.regs[1] = 64'hdead_beef_ffff_ffff;
      u_uwm_regfile.regs[2] = 64'h1234_5678_ffff_ffff;
      u_uwm_regfile.regs[3] = 64'h5555_5555_0000_0002;
      u_uwm_regfile.regs[4] = 64'haaaa_aaaa_8000_0000;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_ops();
      t_illegal();
      t_regs();
      report_and_stop();
   end

   // the whole sequence needs well under a thousand cycles
   initial
   begin
      #20000;
      failures++;
      report_and_stop();
   end
endmodule
